// ==== design/adc_seq_pkg.sv ====
// Purpose: shared constants and types of the primary converter sequencer
// Assumes: 20 MHz system clock, 32-bit classic Wishbone register access
// Notes:   times are kept in ns and turned into clock counts here
package adc_seq_pkg;

  localparam int unsigned CLK_PERIOD_NS = 50;

  // acquisition, conversion and ready-pulse times, ns
  localparam int unsigned ACQ0_NS      = 375;
  localparam int unsigned ACQ1_NS      = 2375;
  localparam int unsigned ACQ2_NS      = 6375;
  localparam int unsigned ACQ3_NS      = 14375;
  localparam int unsigned CONV_NS      = 1625;
  localparam int unsigned DAV_PULSE_NS = 1000;

  // least times round up, the pulse is exact
  localparam logic [8:0] ACQ0_CYC = 9'((ACQ0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] ACQ1_CYC = 9'((ACQ1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] ACQ2_CYC = 9'((ACQ2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] ACQ3_CYC = 9'((ACQ3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] CONV_CYC = 9'((CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] DAV_PULSE_CYC = 5'(DAV_PULSE_NS / CLK_PERIOD_NS);

  // register byte offsets
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_CHSEL0 = 8'h04;
  localparam logic [7:0] ADDR_CHSEL1 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] THR_BASE    = 8'h20;
  localparam logic [7:0] DATA_BASE   = 8'h40;

  // configuration fields
  localparam int unsigned CFG_MODE_BIT  = 0;
  localparam int unsigned CFG_INTERNAL_CONVERT_BIT_BIT = 1;
  localparam int unsigned CFG_DATA_AVAILABLE_FLAG_BIT  = 2;
  localparam int unsigned CFG_RATE_LSB  = 4;

  // channel-select fields: sel0 [1:0] pair enables, [5:2] singles 0..3
  localparam int unsigned SEL0_SINGLE_LSB = 2;
  localparam int unsigned NUM_SLOTS       = 18;

  // reset values
  localparam logic        MODE_RESET  = 1'b0;
  localparam logic [1:0]  RATE_RESET  = 2'h0;
  localparam logic [5:0]  SEL0_RESET  = 6'h00;
  localparam logic [11:0] SEL1_RESET  = 12'h000;

  localparam logic MODE_DIRECT = 1'b0;
  localparam logic MODE_AUTO   = 1'b1;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_NAP    = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_CONV   = 4'b1000
  } seq_state_t;

endpackage

// ==== design/primary_adc_sequencer.sv ====
// Purpose: sequencer of a 16-input successive-approximation converter with
//          double-buffered results behind a classic Wishbone slave
// Assumes: adc_result_i comes from converter logic on clk_i
// Notes:   one-cycle ack on every access, unmapped reads return zero
`timescale 1ns/1ps
module primary_adc_sequencer #(
  parameter int unsigned NUM_CH = 16,
  parameter int unsigned DATA_W = 12
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              ext_convert_trigger_i,
  input  wire logic [DATA_W-1:0] adc_result_i,
  output logic      [3:0]        adc_channel_o,
  output logic                   adc_diff_o,
  output logic                   adc_sample_o,
  output logic                   adc_convert_o,
  output logic                   adc_nap_o,
  output logic                   data_available_pin_n_o
);

  if (NUM_CH != 16 || DATA_W < 2 || DATA_W > 16) begin : g_bad_params
    $error("primary_adc_sequencer: NUM_CH must be 16, DATA_W 2..16");
  end

  // trigger pin synchroniser and falling-edge detector
  logic trig_meta_r;
  logic trig_sync_r;
  logic trig_prev_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_meta_r <= 1'b1;
      trig_sync_r <= 1'b1;
      trig_prev_r <= 1'b1;
    end else begin
      trig_meta_r <= ext_convert_trigger_i;
      trig_sync_r <= trig_meta_r;
      trig_prev_r <= trig_sync_r;
    end
  end

  logic ext_fall;
  assign ext_fall = trig_prev_r & ~trig_sync_r;

  // bus decode
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic hit_cfg;
  logic hit_sel0;
  logic hit_sel1;
  logic hit_stat;
  logic hit_thr;
  logic hit_data;
  logic [15:0] wmask;

  assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr   = bus_req & wb_we_i;
  assign bus_rd   = bus_req & ~wb_we_i;
  assign hit_cfg  = wb_adr_i == adc_seq_pkg::ADDR_CFG;
  assign hit_sel0 = wb_adr_i == adc_seq_pkg::ADDR_CHSEL0;
  assign hit_sel1 = wb_adr_i == adc_seq_pkg::ADDR_CHSEL1;
  assign hit_stat = wb_adr_i == adc_seq_pkg::ADDR_STATUS;
  assign hit_thr  = (wb_adr_i[7:5] == adc_seq_pkg::THR_BASE[7:5]) && (wb_adr_i[1:0] == 2'h0);
  assign hit_data = (wb_adr_i[7:6] == adc_seq_pkg::DATA_BASE[7:6]) && (wb_adr_i[1:0] == 2'h0);
  assign wmask    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // configuration registers
  logic        mode_r;
  logic [1:0]  rate_r;
  logic [5:0]  sel0_r;
  logic [11:0] sel1_r;
  logic [DATA_W-1:0] thr_r [8];
  logic [15:0] sel0_m;
  logic [15:0] sel1_m;
  logic [15:0] thr_m;

  assign sel0_m = ({10'h000, sel0_r} & ~wmask) | (wb_dat_i[15:0] & wmask);
  assign sel1_m = ({4'h0, sel1_r} & ~wmask) | (wb_dat_i[15:0] & wmask);
  assign thr_m  = (16'(thr_r[wb_adr_i[4:2]]) & ~wmask) | (wb_dat_i[15:0] & wmask);

  logic cfg_wr;
  logic mode_change;
  logic internal_convert_bit_wr;
  logic abort_cfg;
  logic sw_trig;
  logic trigger;

  assign cfg_wr      = bus_wr & hit_cfg & wb_sel_i[0];
  assign mode_change = cfg_wr & (wb_dat_i[adc_seq_pkg::CFG_MODE_BIT] != mode_r);
  assign internal_convert_bit_wr    = cfg_wr & wb_dat_i[adc_seq_pkg::CFG_INTERNAL_CONVERT_BIT_BIT];
  // a mode change wins over a convert bit in the same write
  assign sw_trig     = internal_convert_bit_wr & ~mode_change;
  assign abort_cfg   = mode_change | (bus_wr & (hit_sel0 | hit_sel1 | hit_thr));
  assign trigger     = ext_fall | sw_trig;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= adc_seq_pkg::MODE_RESET;
      rate_r <= adc_seq_pkg::RATE_RESET;
    end else if (cfg_wr) begin
      mode_r <= wb_dat_i[adc_seq_pkg::CFG_MODE_BIT];
      rate_r <= wb_dat_i[adc_seq_pkg::CFG_RATE_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel0_r <= adc_seq_pkg::SEL0_RESET;
      sel1_r <= adc_seq_pkg::SEL1_RESET;
    end else begin
      if (bus_wr && hit_sel0) begin
        sel0_r <= sel0_m[5:0];
      end
      if (bus_wr && hit_sel1) begin
        sel1_r <= sel1_m[11:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        thr_r[i] <= '0;
      end
    end else if (bus_wr && hit_thr) begin
      thr_r[wb_adr_i[4:2]] <= thr_m[DATA_W-1:0];
    end
  end

  // slot map: 0,1 differential pairs, 2..17 single channels 0..15
  logic [17:0] en_vec;
  always_comb begin
    en_vec[0]     = sel0_r[0];
    en_vec[1]     = sel0_r[1];
    en_vec[2]     = sel0_r[adc_seq_pkg::SEL0_SINGLE_LSB]     & ~sel0_r[0];
    en_vec[3]     = sel0_r[adc_seq_pkg::SEL0_SINGLE_LSB + 1] & ~sel0_r[0];
    en_vec[4]     = sel0_r[adc_seq_pkg::SEL0_SINGLE_LSB + 2] & ~sel0_r[1];
    en_vec[5]     = sel0_r[adc_seq_pkg::SEL0_SINGLE_LSB + 3] & ~sel0_r[1];
    en_vec[17:6]  = sel1_r;
  end

  // lowest enabled slot at or above from; bit 5 flags a hit
  function automatic logic [5:0] find_slot(input logic [17:0] en, input logic [4:0] from);
    logic       found;
    logic [4:0] idx;
    found = 1'b0;
    idx   = 5'h00;
    for (int i = 0; i < adc_seq_pkg::NUM_SLOTS; i++) begin
      if (!found && (5'(i) >= from) && en[i]) begin
        found = 1'b1;
        idx   = 5'(i);
      end
    end
    return {found, idx};
  endfunction

  function automatic logic [3:0] addr_of(input logic [4:0] slot);
    return (slot < 5'h02) ? 4'(slot << 1) : 4'(slot - 5'h02);
  endfunction

  // sequencer
  adc_seq_pkg::seq_state_t state_r;
  logic [4:0] slot_r;
  logic [8:0] cnt_r;
  logic [8:0] acq_cyc;
  logic [5:0] first_hit;
  logic [5:0] next_hit;
  adc_seq_pkg::seq_state_t enter_state;
  logic [8:0] enter_cnt;
  logic eoc;
  logic [1:0] rate_use;

  // a write that sets the rate and triggers at once starts with the new rate
  assign rate_use = cfg_wr ? wb_dat_i[adc_seq_pkg::CFG_RATE_LSB +: 2] : rate_r;

  always_comb begin
    case (rate_use)
      2'h0:    acq_cyc = adc_seq_pkg::ACQ0_CYC;
      2'h1:    acq_cyc = adc_seq_pkg::ACQ1_CYC;
      2'h2:    acq_cyc = adc_seq_pkg::ACQ2_CYC;
      default: acq_cyc = adc_seq_pkg::ACQ3_CYC;
    endcase
    // nap fills the acquisition time beyond the shortest sample window
    if (rate_use == 2'h0) begin
      enter_state = adc_seq_pkg::ST_SAMPLE;
      enter_cnt   = adc_seq_pkg::ACQ0_CYC - 9'h001;
    end else begin
      enter_state = adc_seq_pkg::ST_NAP;
      enter_cnt   = acq_cyc - adc_seq_pkg::ACQ0_CYC - 9'h001;
    end
  end

  assign first_hit = find_slot(en_vec, 5'h00);
  assign next_hit  = find_slot(en_vec, 5'(slot_r + 5'h01));
  assign eoc = (state_r == adc_seq_pkg::ST_CONV) && (cnt_r == 9'h000) && !trigger && !abort_cfg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= adc_seq_pkg::ST_IDLE;
      slot_r  <= 5'h00;
      cnt_r   <= 9'h000;
    end else if (trigger) begin
      // restart at once; start latency is far below 4 us
      if (first_hit[5]) begin
        state_r <= enter_state;
        slot_r  <= first_hit[4:0];
        cnt_r   <= enter_cnt;
      end else begin
        state_r <= adc_seq_pkg::ST_IDLE;
      end
    end else if (abort_cfg) begin
      state_r <= adc_seq_pkg::ST_IDLE;
    end else begin
      case (state_r)
        adc_seq_pkg::ST_IDLE: begin
          state_r <= adc_seq_pkg::ST_IDLE;
        end
        adc_seq_pkg::ST_NAP: begin
          if (cnt_r == 9'h000) begin
            state_r <= adc_seq_pkg::ST_SAMPLE;
            cnt_r   <= adc_seq_pkg::ACQ0_CYC - 9'h001;
          end else begin
            cnt_r <= cnt_r - 9'h001;
          end
        end
        adc_seq_pkg::ST_SAMPLE: begin
          if (cnt_r == 9'h000) begin
            state_r <= adc_seq_pkg::ST_CONV;
            cnt_r   <= adc_seq_pkg::CONV_CYC - 9'h001;
          end else begin
            cnt_r <= cnt_r - 9'h001;
          end
        end
        adc_seq_pkg::ST_CONV: begin
          if (cnt_r != 9'h000) begin
            cnt_r <= cnt_r - 9'h001;
          end else if (next_hit[5]) begin
            state_r <= enter_state;
            slot_r  <= next_hit[4:0];
            cnt_r   <= enter_cnt;
          end else if (mode_r == adc_seq_pkg::MODE_AUTO && first_hit[5]) begin
            state_r <= enter_state;
            slot_r  <= first_hit[4:0];
            cnt_r   <= enter_cnt;
          end else begin
            state_r <= adc_seq_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= adc_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // converter controls, registered from the sequencer state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_channel_o <= 4'h0;
      adc_diff_o    <= 1'b0;
      adc_sample_o  <= 1'b0;
      adc_convert_o <= 1'b0;
      adc_nap_o     <= 1'b0;
    end else begin
      adc_channel_o <= addr_of(slot_r);
      adc_diff_o    <= slot_r < 5'h02;
      adc_sample_o  <= state_r == adc_seq_pkg::ST_SAMPLE;
      adc_convert_o <= state_r == adc_seq_pkg::ST_CONV;
      adc_nap_o     <= state_r == adc_seq_pkg::ST_NAP;
    end
  end

  // result capture, one cycle after the last conversion count
  logic       eoc_d_r;
  logic       last_d_r;
  logic [4:0] slot_d_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eoc_d_r  <= 1'b0;
      last_d_r <= 1'b0;
      slot_d_r <= 5'h00;
    end else begin
      eoc_d_r  <= eoc;
      last_d_r <= eoc & ~next_hit[5];
      slot_d_r <= slot_r;
    end
  end

  logic [DATA_W-1:0] stage_r [NUM_CH];
  logic [DATA_W-1:0] data_r  [NUM_CH];
  logic [DATA_W-1:0] result_fmt;
  logic              upd_pend_r;
  logic              data_rd_busy;
  logic              do_update;

  // differential code is offset binary with the sign bit turned over
  assign result_fmt   = (slot_d_r < 5'h02) ?
                        {~adc_result_i[DATA_W-1], adc_result_i[DATA_W-2:0]} : adc_result_i;
  assign data_rd_busy = bus_rd & hit_data;
  assign do_update    = upd_pend_r & ~data_rd_busy;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        stage_r[i] <= '0;
      end
    end else if (eoc_d_r) begin
      stage_r[addr_of(slot_d_r)] <= result_fmt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_pend_r <= 1'b0;
    end else begin
      upd_pend_r <= (eoc_d_r & last_d_r) | (upd_pend_r & ~do_update);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        data_r[i] <= '0;
      end
    end else if (do_update) begin
      for (int i = 0; i < NUM_CH; i++) begin
        data_r[i] <= stage_r[i];
      end
    end
  end

  // data-available flag and pin
  logic       data_available_flag_r;
  logic       data_available_flag_nxt;
  logic [4:0] pulse_r;
  logic [4:0] pulse_nxt;

  always_comb begin
    data_available_flag_nxt  = data_available_flag_r;
    pulse_nxt = (pulse_r != 5'h00) ? pulse_r - 5'h01 : 5'h00;
    if (mode_r == adc_seq_pkg::MODE_AUTO) begin
      data_available_flag_nxt = 1'b0;
      if (do_update) begin
        pulse_nxt = adc_seq_pkg::DAV_PULSE_CYC;
      end
    end else begin
      pulse_nxt = 5'h00;
      if (data_rd_busy || ext_fall) begin
        data_available_flag_nxt = 1'b0;
      end
      if (do_update) begin
        data_available_flag_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_available_flag_r                 <= 1'b0;
      pulse_r                <= 5'h00;
      data_available_pin_n_o <= 1'b1;
    end else begin
      data_available_flag_r                 <= data_available_flag_nxt;
      pulse_r                <= pulse_nxt;
      data_available_pin_n_o <= ~(data_available_flag_nxt | (pulse_nxt != 5'h00));
    end
  end

  // bus answer: ack one cycle after the request, read data latched with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        if (hit_cfg) begin
          wb_dat_o <= {26'h000_0000, rate_r, 1'b0, data_available_flag_r, 1'b0, mode_r};
        end else if (hit_sel0) begin
          wb_dat_o <= {26'h000_0000, sel0_r};
        end else if (hit_sel1) begin
          wb_dat_o <= {20'h0_0000, sel1_r};
        end else if (hit_stat) begin
          wb_dat_o <= {19'h0_0000, slot_r, 3'h0, upd_pend_r, state_r};
        end else if (hit_thr) begin
          wb_dat_o <= 32'(thr_r[wb_adr_i[4:2]]);
        end else if (hit_data) begin
          wb_dat_o <= 32'(data_r[wb_adr_i[5:2]]);
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

endmodule // primary_adc_sequencer

// ==== testbench/adc_front_model.sv ====
// Purpose: converter core stand-in answering the sequencer's channel requests
// Assumes: result is sampled in the last convert cycle
// Notes:   code is {channel, diff, 7'h35}; inverted outside a conversion
`timescale 1ns/1ps
module adc_front_model #(
  parameter int unsigned DATA_W = 12
) (
  input  wire logic [3:0]        adc_channel_i,
  input  wire logic              adc_diff_i,
  input  wire logic              adc_convert_i,
  output logic      [DATA_W-1:0] adc_result_o
);
  logic [DATA_W-1:0] code;
  // the raw code names its channel so a misplaced result shows
  assign code = DATA_W'({adc_channel_i, adc_diff_i, 7'h35});
  // no stale result is held outside a conversion
  assign adc_result_o = adc_convert_i ? code : ~code;
endmodule // adc_front_model

// ==== testbench/primary_adc_sequencer_properties.sv ====
// Purpose: port checks of the converter sequencer
// Assumes: one clock, synchronous active-high reset
// Notes:   mode and rate are shadowed from bus writes
`timescale 1ns/1ps
module adc_seq_checker #(
  parameter int unsigned NUM_CH = 16,
  parameter int unsigned DATA_W = 12
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic              wb_we_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              ext_convert_trigger_i,
  input wire logic [DATA_W-1:0] adc_result_i,
  input wire logic [3:0]        adc_channel_o,
  input wire logic              adc_diff_o,
  input wire logic              adc_sample_o,
  input wire logic              adc_convert_o,
  input wire logic              adc_nap_o,
  input wire logic              data_available_pin_n_o
);
  logic       mode_r;
  logic [1:0] rate_r;
  logic       auto_fall_r;
  logic [5:0] low_cnt_r;
  logic [8:0] samp_cnt_r;
  logic [8:0] conv_cnt_r;
  logic       req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= 1'b0;
      rate_r <= 2'h0;
    end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == adc_seq_pkg::ADDR_CFG) begin
      mode_r <= wb_dat_i[adc_seq_pkg::CFG_MODE_BIT];
      rate_r <= wb_dat_i[adc_seq_pkg::CFG_RATE_LSB +: 2];
    end
  end
  // mode in force when the ready pin last went low
  always_ff @(posedge clk_i) begin
    auto_fall_r <= data_available_pin_n_o ? mode_r : auto_fall_r;
    low_cnt_r <= data_available_pin_n_o ? 6'h00 : low_cnt_r + 6'h01;
  end
  always_ff @(posedge clk_i) begin
    samp_cnt_r <= adc_sample_o ? samp_cnt_r + 9'h001 : 9'h000;
    conv_cnt_r <= adc_convert_o ? conv_cnt_r + 9'h001 : 9'h000;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (req |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  unmapped_zero_a: assert property (req && !wb_we_i && wb_adr_i == 8'h10 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && data_available_pin_n_o && !adc_sample_o && !adc_convert_o)
    else $error("outputs active after reset");
  conv_after_sample_a: assert property ($rose(adc_convert_o) |-> $past(adc_sample_o))
    else $error("conversion without sampling");
  sample_len_a: assert property ($fell(adc_sample_o) && adc_convert_o |->
    samp_cnt_r == adc_seq_pkg::ACQ0_CYC) else $error("sample window length wrong");
  conv_len_a: assert property (adc_convert_o |-> conv_cnt_r < adc_seq_pkg::CONV_CYC)
    else $error("conversion too long");
  nap_rate_a: assert property (adc_nap_o |->
    rate_r != 2'h0 || $past(rate_r) != 2'h0 || $past(rate_r, 2) != 2'h0)
    else $error("nap at fastest rate");
  auto_pulse_a: assert property ($rose(data_available_pin_n_o) && auto_fall_r |->
    low_cnt_r == 6'(adc_seq_pkg::DAV_PULSE_CYC)) else $error("auto ready pulse length wrong");
  nap_seen_c: cover property ($fell(adc_nap_o) && adc_sample_o);
  auto_pulse_c: cover property ($rose(data_available_pin_n_o) && auto_fall_r);
  direct_ready_c: cover property ($fell(data_available_pin_n_o) && !mode_r);
endmodule // adc_seq_checker

bind primary_adc_sequencer adc_seq_checker #(.NUM_CH(NUM_CH), .DATA_W(DATA_W)) u_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_convert_trigger_i(ext_convert_trigger_i),
  .adc_result_i(adc_result_i), .adc_channel_o(adc_channel_o), .adc_diff_o(adc_diff_o),
  .adc_sample_o(adc_sample_o), .adc_convert_o(adc_convert_o), .adc_nap_o(adc_nap_o),
  .data_available_pin_n_o(data_available_pin_n_o));

// ==== testbench/primary_adc_sequencer_bench.sv ====
// Purpose: self-checking bench of the converter sequencer
// Assumes: 20 MHz clock, one-cycle Wishbone answer
// Notes:   the partner model codes each result with its channel
`timescale 1ns/1ps
module primary_adc_sequencer_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [3:0]  wb_sel = 4'h0;
  logic        wb_we = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        ext_trig = 1'b1;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [11:0] adc_result;
  logic [3:0]  adc_channel;
  logic        adc_diff, adc_sample, adc_convert, adc_nap, dav_n;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic [4:0]  order [4] = '{5'h12, 5'h00, 5'h04, 5'h0F};
  logic [8:0]  acq [4] = '{adc_seq_pkg::ACQ0_CYC, adc_seq_pkg::ACQ1_CYC,
                           adc_seq_pkg::ACQ2_CYC, adc_seq_pkg::ACQ3_CYC};
  int          n;
  logic [31:0] q;

  primary_adc_sequencer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
    .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .ext_convert_trigger_i(ext_trig), .adc_result_i(adc_result),
    .adc_channel_o(adc_channel), .adc_diff_o(adc_diff), .adc_sample_o(adc_sample),
    .adc_convert_o(adc_convert), .adc_nap_o(adc_nap), .data_available_pin_n_o(dav_n));
  adc_front_model u_front (.adc_channel_i(adc_channel), .adc_diff_i(adc_diff),
    .adc_convert_i(adc_convert), .adc_result_o(adc_result));

  always #25 clk_i = ~clk_i;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_adr <= a;
    wb_we <= w;
    wb_dat <= d;
    wb_sel <= 4'h3;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(q, e);
  endtask

  function automatic logic [31:0] res_exp(input logic [3:0] ch, input logic d);
    logic [11:0] c;
    c = {ch, d, 7'h35};
    if (d) c = c ^ 12'h800;
    return {20'h0_0000, c};
  endfunction

  function automatic logic pick(input int k);
    return k == 0 ? adc_nap : k == 1 ? adc_sample : k == 2 ? adc_convert : ~dav_n;
  endfunction

  // length in cycles of the next high stretch of a phase output, or low stretch of the ready pin
  task automatic measure(input int k);
    n = 0;
    while (pick(k) !== 1'b1) @(posedge clk_i);
    while (pick(k) === 1'b1) begin
      n++;
      @(posedge clk_i);
    end
  endtask

  task automatic wait_sample();
    while (adc_sample !== 1'b1) @(posedge clk_i);
  endtask

  task automatic wait_ready();
    while (dav_n !== 1'b0) @(posedge clk_i);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd_chk(adc_seq_pkg::ADDR_CFG, 32'h0);
    rd_chk(adc_seq_pkg::ADDR_CHSEL0, 32'h0);
    rd_chk(adc_seq_pkg::ADDR_CHSEL1, 32'h0);
    rd_chk(8'h10, 32'h0);
    chk(32'(dav_n), 32'h1);
    $display("test reset done");
    xfer(adc_seq_pkg::ADDR_CHSEL0, 1'b1, 32'h0000_0006);
    xfer(adc_seq_pkg::ADDR_CHSEL1, 1'b1, 32'h0000_0801);
    xfer(adc_seq_pkg::ADDR_CFG, 1'b1, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      wait_sample();
      chk(32'({adc_diff, adc_channel}), 32'(order[i]));
      while (adc_sample === 1'b1) @(posedge clk_i);
    end
    wait_ready();
    chk(32'(adc_sample), 32'h0);
    rd_chk(adc_seq_pkg::ADDR_CFG, 32'h0000_0004);
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'(adc_seq_pkg::DATA_BASE + 4 * order[i][3:0]),
             res_exp(order[i][3:0], order[i][4]));
    end
    rd_chk(adc_seq_pkg::DATA_BASE + 8'h04, 32'h0);
    chk(32'(dav_n), 32'h1);
    $display("test direct group done");
    xfer(adc_seq_pkg::ADDR_CHSEL0, 1'b1, 32'h0);
    xfer(adc_seq_pkg::ADDR_CHSEL1, 1'b1, 32'h0000_0001);
    for (int r = 0; r < 4; r++) begin
      xfer(adc_seq_pkg::ADDR_CFG, 1'b1, 32'(r << 4) | 32'h0000_0002);
      if (r != 0) begin
        measure(0);
        chk(32'(n), 32'(acq[r] - adc_seq_pkg::ACQ0_CYC));
      end
      measure(1);
      chk(32'(n), 32'(adc_seq_pkg::ACQ0_CYC));
      measure(2);
      chk(32'(n), 32'(adc_seq_pkg::CONV_CYC));
      wait_ready();
      rd_chk(adc_seq_pkg::DATA_BASE + 8'h10, res_exp(4'h4, 1'b0));
    end
    $display("test rates done");
    xfer(adc_seq_pkg::ADDR_CHSEL1, 1'b1, 32'h0000_0003);
    xfer(adc_seq_pkg::ADDR_CFG, 1'b1, 32'h0000_0001);
    xfer(adc_seq_pkg::ADDR_CFG, 1'b1, 32'h0000_0003);
    while (!(adc_channel === 4'h5 && adc_convert === 1'b1)) @(posedge clk_i);
    xfer(adc_seq_pkg::ADDR_CFG, 1'b1, 32'h0000_0003);
    wait_sample();
    chk(32'(adc_channel), 32'h4);
    measure(3);
    chk(32'(n), 32'(adc_seq_pkg::DAV_PULSE_CYC));
    // two channels per group: pin high for the group time less the pulse
    q = 32'(2 * (adc_seq_pkg::ACQ0_CYC + adc_seq_pkg::CONV_CYC) - adc_seq_pkg::DAV_PULSE_CYC);
    n = 0;
    while (dav_n === 1'b1) begin
      n++;
      @(posedge clk_i);
    end
    chk(32'(n), q);
    measure(3);
    chk(32'(n), 32'(adc_seq_pkg::DAV_PULSE_CYC));
    rd_chk(adc_seq_pkg::ADDR_CFG, 32'h0000_0001);
    xfer(adc_seq_pkg::THR_BASE, 1'b1, 32'h0000_0123);
    repeat (45) @(posedge clk_i);
    chk(32'({adc_sample, adc_convert}), 32'h0);
    xfer(adc_seq_pkg::ADDR_CFG, 1'b1, 32'h0000_0003);
    wait_sample();
    xfer(adc_seq_pkg::ADDR_CFG, 1'b1, 32'h0000_0002);
    repeat (45) @(posedge clk_i);
    chk(32'({adc_sample, adc_convert}), 32'h0);
    $display("test auto and aborts done");
    xfer(adc_seq_pkg::ADDR_CHSEL1, 1'b1, 32'h0000_0001);
    ext_trig <= 1'b0;
    wait_sample();
    chk(32'(adc_channel), 32'h4);
    wait_ready();
    repeat (60) @(posedge clk_i);
    chk(32'({adc_sample, dav_n}), 32'h0);
    ext_trig <= 1'b1;
    @(posedge clk_i);
    ext_trig <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(32'(dav_n), 32'h1);
    wait_ready();
    rd_chk(adc_seq_pkg::DATA_BASE + 8'h10, res_exp(4'h4, 1'b0));
    ext_trig <= 1'b1;
    $display("test external trigger done");
    finish_test();
  end
endmodule // primary_adc_sequencer_bench
